// ==== rtl/eictmr_device.sv ====
// Third interval unit, carrier output control and port 3 direction register.
// Assumes a controller on the link and synchronous companion counter inputs.
`default_nettype none
module eictmr_device
    import eictmr_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register link
    eictmr_if.device bus,
    // Second unit and companion counter
    input wire logic i_unit2_run,
    input wire logic i_unit2_timer_out,
    input wire logic i_companion_match_irq,
    // Outputs
    output logic o_interval_match_irq,
    output logic o_unit3_timer_out,
    output logic o_remote_out,
    output logic [7:0] o_port3_dir
);
    logic [7:0] port3_direction;
    logic [7:0] unit3_timer_mode;
    logic [7:0] period_compare;
    logic [7:0] duty_compare;
    logic [7:0] unit2_carrier_control;
    logic [PRE_W-1:0] prescale;
    logic [7:0] count;
    logic timer_out;
    logic pwm_active;
    logic irq_prev;
    logic count_tick;
    logic unit3_run;
    logic mode_ok;
    logic [2:0] clksel;
    logic [1:0] opmode;

    // Enable pulse when the low bits of the free prescaler are all ones
    function automatic logic sel_tick(input logic [2:0] sel, input logic [PRE_W-1:0] pre);
        logic [PRE_W-1:0] mask;
        mask = '0;
        case (sel)
            3'b000: mask = '0;
            3'b001: mask = PRE_W'((1 << SHIFT_DIV2) - 1);
            3'b010: mask = PRE_W'((1 << SHIFT_DIV4) - 1);
            3'b011: mask = PRE_W'((1 << SHIFT_DIV16) - 1);
            3'b100: mask = PRE_W'((1 << SHIFT_DIV64) - 1);
            3'b101: mask = PRE_W'((1 << SHIFT_DIV1024) - 1);
            3'b110: mask = PRE_W'((1 << SHIFT_DIV4096) - 1);
            default: mask = PRE_W'((1 << SHIFT_DIV4096) - 1);
        endcase
        return (pre & mask) == mask;
    endfunction

    assign unit3_run = unit3_timer_mode[MODE_RUN_BIT];
    assign clksel = unit3_timer_mode[MODE_CKS_HI:MODE_CKS_LO];
    assign opmode = unit3_timer_mode[MODE_OPM_HI:MODE_OPM_LO];
    assign count_tick = sel_tick(clksel, prescale);
    // Config may change only while stopped, or the write repeats it
    assign mode_ok = !unit3_run || ((bus.wdata & MODE_CFG_MASK) == (unit3_timer_mode & MODE_CFG_MASK));

    // Free-running prescaler
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + PRE_W'(1);
        end
    end

    // Mode register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            unit3_timer_mode <= RST_UNIT3_MODE;
        end else if (bus.wr && bus.addr == ADDR_UNIT3_MODE && mode_ok) begin
            unit3_timer_mode <= bus.wdata;
        end
    end

    // Compare registers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            period_compare <= RST_COMPARE;
            duty_compare <= RST_COMPARE;
        end else if (bus.wr) begin
            if (bus.addr == ADDR_UNIT3_PERIOD) begin
                period_compare <= bus.wdata;
            end
            if (bus.addr == ADDR_UNIT3_DUTY) begin
                duty_compare <= bus.wdata;
            end
        end
    end

    // Port 3 direction
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            port3_direction <= RST_PORT3_DIR;
        end else if (bus.wr && bus.addr == ADDR_PORT3_DIR) begin
            port3_direction <= bus.wdata | PORT3_FIXED_ONES;
        end
    end

    // Carrier control, flag loaded from level bit on companion request edge
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            unit2_carrier_control <= RST_CARRIER_CTL;
            irq_prev <= 1'b0;
        end else begin
            irq_prev <= i_companion_match_irq;
            if (bus.wr && bus.addr == ADDR_CARRIER_CTL) begin
                if (!i_unit2_run || bus.wdata[CYC_RMC_BIT] == unit2_carrier_control[CYC_RMC_BIT]) begin
                    unit2_carrier_control[CYC_RMC_BIT] <= bus.wdata[CYC_RMC_BIT];
                end
                unit2_carrier_control[CYC_LEVEL_BIT] <= bus.wdata[CYC_LEVEL_BIT];
            end
            if (i_companion_match_irq && !irq_prev) begin
                unit2_carrier_control[CYC_FLAG_BIT] <= unit2_carrier_control[CYC_LEVEL_BIT];
            end
        end
    end

    // Remote control output
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_remote_out <= 1'b0;
        end else if (!unit2_carrier_control[CYC_FLAG_BIT]) begin
            o_remote_out <= 1'b0;
        end else if (unit2_carrier_control[CYC_RMC_BIT]) begin
            o_remote_out <= i_unit2_timer_out;
        end else begin
            o_remote_out <= 1'b1;
        end
    end

    // Counter and match logic
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            count <= '0;
            o_interval_match_irq <= 1'b0;
            pwm_active <= 1'b0;
        end else if (!unit3_run) begin
            count <= '0;
            o_interval_match_irq <= 1'b0;
            pwm_active <= 1'b0;
        end else begin
            o_interval_match_irq <= 1'b0;
            if (count_tick) begin
                if (count == period_compare) begin
                    count <= '0;
                    o_interval_match_irq <= 1'b1;
                    pwm_active <= 1'b1;
                end else begin
                    count <= count + 8'h01;
                    // Second compare only matters in PWM mode
                    if (opmode == EICTMR_OPM_PWM && count == duty_compare) begin
                        pwm_active <= 1'b0;
                    end
                end
            end
        end
    end

    // Timer output level
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            timer_out <= 1'b0;
        end else if (!unit3_run || !unit3_timer_mode[MODE_OE_BIT]) begin
            timer_out <= unit3_timer_mode[MODE_LEVEL_BIT];
        end else if (opmode == EICTMR_OPM_PWM) begin
            if (count_tick && count == period_compare) begin
                timer_out <= !unit3_timer_mode[MODE_LEVEL_BIT];
            end else if (count_tick && pwm_active && count == duty_compare) begin
                timer_out <= unit3_timer_mode[MODE_LEVEL_BIT];
            end
        end else if (count_tick && count == period_compare) begin
            timer_out <= !timer_out;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            bus.rdata <= '0;
        end else if (bus.rd) begin
            case (bus.addr)
                ADDR_PORT3_DIR: bus.rdata <= port3_direction;
                ADDR_UNIT3_MODE: bus.rdata <= unit3_timer_mode;
                ADDR_UNIT3_PERIOD: bus.rdata <= period_compare;
                ADDR_UNIT3_DUTY: bus.rdata <= duty_compare;
                ADDR_CARRIER_CTL: bus.rdata <= unit2_carrier_control;
                default: bus.rdata <= '0;
            endcase
        end else begin
            bus.rdata <= '0;
        end
    end

    // Registered copies for the ports
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_unit3_timer_out <= 1'b0;
            o_port3_dir <= RST_PORT3_DIR;
        end else begin
            o_unit3_timer_out <= timer_out;
            o_port3_dir <= port3_direction;
        end
    end
endmodule
`default_nettype wire

// ==== include/eictmr_pkg.sv ====
// Constants shared by the timer group's device end and its controller end.
// Assumes a single 100 MHz clock and byte-wide register data on the link.
`default_nettype none
package eictmr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PRE_W = 12;
    // Device register addresses
    localparam logic [15:0] ADDR_PORT3_DIR = 16'hff23;
    localparam logic [15:0] ADDR_UNIT3_MODE = 16'hff42;
    localparam logic [15:0] ADDR_UNIT3_PERIOD = 16'hff43;
    localparam logic [15:0] ADDR_UNIT3_DUTY = 16'hff44;
    localparam logic [15:0] ADDR_CARRIER_CTL = 16'hff6d;
    // Reset values and fixed bits
    localparam logic [7:0] RST_PORT3_DIR = 8'hff;
    localparam logic [7:0] PORT3_FIXED_ONES = 8'he0;
    localparam logic [7:0] RST_UNIT3_MODE = 8'h00;
    localparam logic [7:0] RST_CARRIER_CTL = 8'h00;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic [7:0] MODE_CFG_MASK = 8'h7f;
    // Mode register fields
    localparam int MODE_RUN_BIT = 7;
    localparam int MODE_CKS_HI = 6;
    localparam int MODE_CKS_LO = 4;
    localparam int MODE_OPM_HI = 3;
    localparam int MODE_OPM_LO = 2;
    localparam int MODE_LEVEL_BIT = 1;
    localparam int MODE_OE_BIT = 0;
    // Carrier control fields
    localparam int CYC_RMC_BIT = 2;
    localparam int CYC_LEVEL_BIT = 1;
    localparam int CYC_FLAG_BIT = 0;
    // Operating modes
    typedef enum logic [1:0] {
        EICTMR_OPM_INTERVAL = 2'b00,
        EICTMR_OPM_PWM = 2'b10
    } eictmr_opm_t;
    // Prescaler shift per clock select code
    localparam int SHIFT_DIV1 = 0;
    localparam int SHIFT_DIV2 = 1;
    localparam int SHIFT_DIV4 = 2;
    localparam int SHIFT_DIV16 = 4;
    localparam int SHIFT_DIV64 = 6;
    localparam int SHIFT_DIV1024 = 10;
    localparam int SHIFT_DIV4096 = 12;
    // Controller software register offsets
    localparam logic [1:0] SW_TARGET = 2'h0;
    localparam logic [1:0] SW_WRITE = 2'h1;
    localparam logic [1:0] SW_READ = 2'h2;
    localparam logic [1:0] SW_STATUS = 2'h3;
    localparam int STAT_VALID_BIT = 8;
    localparam int STAT_REFUSED_BIT = 9;
endpackage
`default_nettype wire

// ==== include/eictmr_if.sv ====
// Register link between the timer group and its controller.
// Assumes both ends share one clock; read data follow a read by one cycle.
`default_nettype none
interface eictmr_if;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    modport device (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// ==== rtl/eictmr_host.sv ====
// Controller that drives the timer group's register link for software.
// Assumes software issues one-cycle strobes and reads status before reuse.
`default_nettype none
module eictmr_host
    import eictmr_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Software port
    input wire logic [1:0] i_sw_addr,
    input wire logic [15:0] i_sw_wdata,
    input wire logic i_sw_wr,
    input wire logic i_sw_rd,
    output logic [15:0] o_sw_rdata,
    // Second unit state
    input wire logic i_unit2_run,
    // Register link
    eictmr_if.host bus
);
    logic [15:0] target;
    logic [7:0] mode_shadow;
    logic [7:0] rmc_shadow;
    logic duty_fresh;
    logic read_wait;
    logic [7:0] read_data;
    logic read_valid;
    logic refused;
    logic wr_cmd;
    logic allow;
    logic [7:0] wbyte;

    assign wr_cmd = i_sw_wr && i_sw_addr == SW_WRITE;
    assign wbyte = i_sw_wdata[7:0];

    // Decide whether a write may go out on the link
    always_comb begin
        allow = 1'b1;
        if (target == ADDR_UNIT3_MODE) begin
            if (mode_shadow[MODE_RUN_BIT] && (wbyte & MODE_CFG_MASK) != (mode_shadow & MODE_CFG_MASK)) begin
                allow = 1'b0;
            end
            if (!mode_shadow[MODE_RUN_BIT] && wbyte[MODE_RUN_BIT] && !duty_fresh) begin
                allow = 1'b0;
            end
        end
        if (target == ADDR_CARRIER_CTL && i_unit2_run && wbyte[CYC_RMC_BIT] != rmc_shadow[CYC_RMC_BIT]) begin
            allow = 1'b0;
        end
    end

    // Target address
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            target <= '0;
        end else if (i_sw_wr && i_sw_addr == SW_TARGET) begin
            target <= i_sw_wdata;
        end
    end

    // Shadows of what the device holds
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_shadow <= RST_UNIT3_MODE;
            rmc_shadow <= RST_CARRIER_CTL;
            duty_fresh <= 1'b0;
        end else if (wr_cmd && allow) begin
            if (target == ADDR_UNIT3_MODE) begin
                mode_shadow <= wbyte;
                if (!mode_shadow[MODE_RUN_BIT] && wbyte[MODE_RUN_BIT]) begin
                    duty_fresh <= 1'b0;
                end
            end
            if (target == ADDR_UNIT3_DUTY) begin
                duty_fresh <= 1'b1;
            end
            if (target == ADDR_CARRIER_CTL) begin
                rmc_shadow <= wbyte;
            end
        end
    end

    // Link strobes
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            bus.addr <= '0;
            bus.wdata <= '0;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
        end else begin
            bus.wr <= wr_cmd && allow;
            bus.rd <= i_sw_wr && i_sw_addr == SW_READ;
            if (i_sw_wr && (i_sw_addr == SW_WRITE || i_sw_addr == SW_READ)) begin
                bus.addr <= target;
                bus.wdata <= wbyte;
            end
        end
    end

    // Read capture and refusal flag; setting wins over clearing
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            read_wait <= 1'b0;
            read_data <= '0;
            read_valid <= 1'b0;
            refused <= 1'b0;
        end else begin
            read_wait <= bus.rd;
            if (read_wait) begin
                read_data <= bus.rdata;
                read_valid <= 1'b1;
            end else if (i_sw_rd && i_sw_addr == SW_STATUS) begin
                read_valid <= 1'b0;
            end
            if (wr_cmd && !allow) begin
                refused <= 1'b1;
            end else if (i_sw_rd && i_sw_addr == SW_STATUS) begin
                refused <= 1'b0;
            end
        end
    end

    // Software read data
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sw_rdata <= '0;
        end else if (i_sw_rd) begin
            case (i_sw_addr)
                SW_TARGET: o_sw_rdata <= target;
                SW_STATUS: o_sw_rdata <= {6'h00, refused, read_valid, read_data};
                default: o_sw_rdata <= '0;
            endcase
        end else begin
            o_sw_rdata <= '0;
        end
    end
endmodule
`default_nettype wire

// ==== verification/eictmr_checker.sv ====
// Checker for the register link and the device outputs of the timer group.
// Assumes one clock domain; instantiated beside the link interface.
`default_nettype none
module eictmr_checker
    import eictmr_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register link
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Device pins
    input wire logic i_companion_match_irq,
    input wire logic i_unit2_timer_out,
    input wire logic o_interval_match_irq,
    input wire logic o_unit3_timer_out,
    input wire logic o_remote_out,
    input wire logic [7:0] o_port3_dir
);
    logic lvl_t;
    logic lvl_c;
    wire logic mode_wr = wr && addr == ADDR_UNIT3_MODE;
    // Last default level written to the mode register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            lvl_t <= 1'b0;
        end else if (mode_wr) begin
            lvl_t <= wdata[MODE_LEVEL_BIT];
        end
    end
    // Last level bit written to carrier control
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            lvl_c <= 1'b0;
        end else if (wr && addr == ADDR_CARRIER_CTL) begin
            lvl_c <= wdata[CYC_LEVEL_BIT];
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    dir_pins_fixed_a:
        assert property (o_port3_dir[7:5] == 3'b111) else $error("direction top bits not one");
    dir_read_fixed_a:
        assert property (rd && addr == ADDR_PORT3_DIR |=> rdata[7:5] == 3'b111) else $error("direction read top bits");
    carrier_read_zero_a:
        assert property (rd && addr == ADDR_CARRIER_CTL |=> rdata[7:3] == 5'h00) else $error("carrier read top bits");
    stop_out_default_a:
        assert property (mode_wr && !wdata[MODE_RUN_BIT] |=> ##2 (o_unit3_timer_out == lvl_t) [*2])
        else $error("timer output not at default after stop");
    stop_irq_quiet_a:
        assert property (mode_wr && !wdata[MODE_RUN_BIT] |=> ##1 !o_interval_match_irq [*4])
        else $error("match request while stopped");
    irq_spacing_a:
        assert property (o_interval_match_irq |=> !o_interval_match_irq [*3]) else $error("match requests too close");
    remote_rise_cause_a:
        assert property ($rose(o_remote_out) |-> $past(i_companion_match_irq) || $past(i_unit2_timer_out))
        else $error("remote output rose without cause");
    remote_low_a:
        assert property ($rose(i_companion_match_irq) && !lvl_c |=> ##1 !o_remote_out [*2])
        else $error("remote output not low");
    link_strobes_a:
        assert property (!(wr && rd)) else $error("read and write strobes together");
endmodule
`default_nettype wire

// ==== verification/test_eight_bit_interval_carrier_timer.sv ====
// Self-checking bench: controller and device joined by the link interface.
// Assumes a 100 MHz clock and software driven through the controller port.
`default_nettype none
module test_eight_bit_interval_carrier_timer
    import eictmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SH [7] = '{SHIFT_DIV1, SHIFT_DIV2, SHIFT_DIV4, SHIFT_DIV16, SHIFT_DIV64, SHIFT_DIV1024, SHIFT_DIV4096};
    logic ref_clk;
    logic rst;
    logic [1:0] sw_addr;
    logic [15:0] sw_wdata;
    logic sw_wr;
    logic sw_rd;
    logic [15:0] sw_rdata;
    logic u2_run;
    logic u2_out;
    logic comp;
    logic irq;
    logic t_out;
    logic rem;
    logic [7:0] dir;
    int failures;
    int checks;
    eictmr_if lnk();
    eictmr_device i_eictmr_device (.i_ref_clk(ref_clk), .i_rst(rst), .bus(lnk), .i_unit2_run(u2_run),
        .i_unit2_timer_out(u2_out), .i_companion_match_irq(comp), .o_interval_match_irq(irq),
        .o_unit3_timer_out(t_out), .o_remote_out(rem), .o_port3_dir(dir));
    eictmr_host i_eictmr_host (.i_ref_clk(ref_clk), .i_rst(rst), .i_sw_addr(sw_addr), .i_sw_wdata(sw_wdata),
        .i_sw_wr(sw_wr), .i_sw_rd(sw_rd), .o_sw_rdata(sw_rdata), .i_unit2_run(u2_run), .bus(lnk));
    eictmr_checker i_eictmr_checker (.i_ref_clk(ref_clk), .i_rst(rst), .addr(lnk.addr), .wdata(lnk.wdata),
        .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata), .i_companion_match_irq(comp), .i_unit2_timer_out(u2_out),
        .o_interval_match_irq(irq), .o_unit3_timer_out(t_out), .o_remote_out(rem), .o_port3_dir(dir));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task sw_cyc(input logic [1:0] a, input logic [15:0] d, input logic w);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= w;
        sw_rd <= ~w;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
        #1;
    endtask
    task wr_reg(input logic [15:0] a, input logic [7:0] d);
        sw_cyc(SW_TARGET, a, 1'b1);
        sw_cyc(SW_WRITE, {8'h00, d}, 1'b1);
    endtask
    // Status word: refused, valid, data
    task rd_reg(input logic [15:0] a, output logic [15:0] s);
        sw_cyc(SW_TARGET, a, 1'b1);
        sw_cyc(SW_READ, 16'h0000, 1'b1);
        repeat (3) @(posedge ref_clk);
        sw_cyc(SW_STATUS, 16'h0000, 1'b0);
        s = sw_rdata;
    endtask
    task start(input logic [7:0] m, input logic [7:0] d);
        wr_reg(ADDR_UNIT3_PERIOD, 8'h03);
        wr_reg(ADDR_UNIT3_DUTY, d);
        wr_reg(ADDR_UNIT3_MODE, m);
    endtask
    // Cycles between two match requests
    task gap(output int g);
        int n;
        n = 0;
        do begin @(posedge ref_clk); #1; n++; end while (irq !== 1'b1 && n < 20000);
        g = 0;
        do begin @(posedge ref_clk); #1; g++; end while (irq !== 1'b1 && g < 20000);
    endtask
    // Toggles and high cycles of the timer output over 16 cycles
    task win(output int t, output int h);
        logic p;
        t = 0;
        h = 0;
        p = t_out;
        repeat (16) begin
            @(posedge ref_clk);
            #1;
            if (t_out !== p) t++;
            if (t_out === 1'b1) h++;
            p = t_out;
        end
    endtask
    task s_regs();
        logic [15:0] s;
        chk("dir_pins", 16'h00ff, {8'h00, dir});
        rd_reg(ADDR_PORT3_DIR, s); chk("dir", 16'h01ff, s);
        rd_reg(ADDR_UNIT3_MODE, s); chk("mode", 16'h0100, s);
        rd_reg(ADDR_CARRIER_CTL, s); chk("carrier", 16'h0100, s);
        rd_reg(16'hfff0, s); chk("unmapped", 16'h0100, s);
        wr_reg(ADDR_PORT3_DIR, 8'h00);
        rd_reg(ADDR_PORT3_DIR, s); chk("dir_wr", 16'h01e0, s);
        chk("dir_pins_wr", 16'h00e0, {8'h00, dir});
        wr_reg(ADDR_CARRIER_CTL, 8'hff);
        rd_reg(ADDR_CARRIER_CTL, s); chk("carrier_wr", 16'h0106, s);
    endtask
    task s_clk();
        int g;
        logic [7:0] m;
        for (int k = 0; k < 7; k++) begin
            m = {1'b1, 3'(k), 4'b0001};
            start(m, 8'h01);
            gap(g); chk("interval", 16'(4 << SH[k]), 16'(g));
            wr_reg(ADDR_UNIT3_MODE, m & 8'h7f);
        end
    endtask
    task s_mode();
        int g;
        int t;
        int h;
        logic [15:0] s;
        start(8'h81, 8'h01);
        gap(g);
        win(t, h); chk("toggles", 16'd4, 16'(t));
        chk("square_high", 16'd8, 16'(h));
        wr_reg(ADDR_UNIT3_MODE, 8'hf1);
        rd_reg(ADDR_UNIT3_MODE, s); chk("locked", 16'h0381, s);
        wr_reg(ADDR_UNIT3_MODE, 8'h01);
        wr_reg(ADDR_UNIT3_MODE, 8'h03);
        repeat (4) @(posedge ref_clk);
        #1;
        chk("idle_level", 16'h0001, {15'h0000, t_out});
        wr_reg(ADDR_UNIT3_MODE, 8'h83);
        rd_reg(ADDR_UNIT3_MODE, s); chk("no_duty", 16'h0303, s);
        start(8'h89, 8'h00);
        gap(g);
        win(t, h); chk("pwm_high", 16'd4, 16'(h));
        wr_reg(ADDR_UNIT3_MODE, 8'h09);
    endtask
    task s_carrier();
        logic [15:0] s;
        for (int c = 0; c < 4; c++) begin
            wr_reg(ADDR_CARRIER_CTL, {5'h00, 2'(c), 1'b0});
            @(posedge ref_clk);
            comp <= 1'b1;
            repeat (3) @(posedge ref_clk);
            comp <= 1'b0;
            #1;
            chk("remote", {15'h0000, c == 1 || c == 3}, {15'h0000, rem});
            if (c == 3) begin
                @(posedge ref_clk);
                u2_out <= 1'b0;
                repeat (3) @(posedge ref_clk);
                #1;
                chk("carrier_pass", 16'h0000, {15'h0000, rem});
            end
            rd_reg(ADDR_CARRIER_CTL, s); chk("flag", {8'h01, 5'h00, 2'(c), c[0]}, s);
        end
        @(posedge ref_clk);
        u2_run <= 1'b1;
        wr_reg(ADDR_CARRIER_CTL, 8'h02);
        rd_reg(ADDR_CARRIER_CTL, s); chk("rmc_locked", 16'h0307, s);
        @(posedge ref_clk);
        u2_run <= 1'b0;
    endtask
    task report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        failures = 0;
        checks = 0;
        rst = 1'b1;
        sw_addr = 2'h0;
        sw_wdata = 16'h0000;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        u2_run = 1'b0;
        u2_out = 1'b1;
        comp = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        s_regs();
        s_clk();
        s_mode();
        s_carrier();
        report_and_stop();
    end
    // Cuts a hang short
    initial begin
        #600_000;
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
